// ---- core/pir_pkg.sv ----
// constants for the pci interrupt router
package pir_pkg;
   // ----------------------------------------
   // line and irq counts
   // ----------------------------------------
   localparam int NUM_LINES = 8;
   localparam int NUM_IRQ_LEGACY = 16;
   localparam int NUM_IRQ_ADV = 24;
   localparam int SEL_W = 4;
   localparam int ADV_LINE_BASE = 16;
   // ----------------------------------------
   // shared line indices
   // ----------------------------------------
   localparam int LINE_A = 0;
   localparam int LINE_B = 1;
   localparam int LINE_C = 2;
   localparam int LINE_D = 3;
   localparam int LINE_E = 4;
   localparam int LINE_F = 5;
   localparam int LINE_G = 6;
   localparam int LINE_H = 7;
   // ----------------------------------------
   // fixed irq numbers
   // ----------------------------------------
   localparam int IRQ_TIMER = 0;
   localparam int IRQ_KBD = 1;
   localparam int IRQ_CASCADE = 2;
   localparam int IRQ_DISKETTE = 6;
   localparam int IRQ_RTC = 8;
   localparam int IRQ_MOUSE = 12;
   localparam int IRQ_FPU = 13;
   localparam int IRQ_DISK_PRI = 14;
   localparam int IRQ_DISK_SEC = 15;
   localparam logic [3:0] SERIAL_ONE_DEFAULT = 4'h4;
   localparam logic [3:0] PARALLEL_ONE_DEFAULT = 4'h7;
   // irqs a shared line may be steered onto in legacy mode
   localparam logic [15:0] LEGACY_SEL_MASK = 16'hDEF8;
   localparam logic [3:0] LINE_SEL_RESET = 4'h0;
   // ----------------------------------------
   // routing mode
   // ----------------------------------------
   typedef enum logic [1:0] {
      PIR_MODE_LEGACY = 2'h1,
      PIR_MODE_ADV = 2'h2
   } pir_mode_e;
endpackage : pir_pkg

// ---- core/pir_router.sv ----
// pci interrupt router: slot and lan pins to shared lines to system irqs
`timescale 1ns/1ns
module pir_router (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic clk_en_in,
   // mode and steering selects
   input wire logic adv_mode_in,
   input wire logic [31:0] line_sel_in,
   input wire logic [3:0] serial_one_sel_in,
   input wire logic [3:0] parallel_one_sel_in,
   input wire logic [3:0] dyn_sel_in,
   // presence straps
   input wire logic mouse_present_in,
   input wire logic disk_pri_present_in,
   input wire logic disk_sec_present_in,
   // pci interrupt pins, active low level; dyn_int_in is active high
   input wire logic [3:0] slot1_int_b_in,
   input wire logic [3:0] slot2_int_b_in,
   input wire logic lan_int_b_in,
   input wire logic dyn_int_in,
   // fixed system sources, active high
   input wire logic timer_in,
   input wire logic kbd_in,
   input wire logic cascade_in,
   input wire logic serial_one_in,
   input wire logic diskette_in,
   input wire logic parallel_one_in,
   input wire logic rtc_in,
   input wire logic mouse_in,
   input wire logic fpu_in,
   input wire logic disk_pri_in,
   input wire logic disk_sec_in,
   input wire logic io_check_in,
   // results
   output logic [7:0] shared_line_out,
   output logic [23:0] irq_out,
   output logic nmi_out,
   output logic adv_active_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] s1_m;
      logic [3:0] s1;
      logic [3:0] s2_m;
      logic [3:0] s2;
      logic lan_m;
      logic lan;
      logic [11:0] sys_m;
      logic [11:0] sys;
      logic dyn_m;
      logic dyn;
      logic [2:0] pres;
      pir_pkg::pir_mode_e mode;
      logic [7:0] lines;
      logic [23:0] irq;
      logic nmi;
   } pir_state_s;

   pir_state_s state_reg;
   pir_state_s state_next;

   // legal legacy target for a shared line
   function automatic logic sel_ok(input logic [3:0] sel);
      sel_ok = pir_pkg::LEGACY_SEL_MASK[sel];
   endfunction : sel_ok

   // one-hot of a 4 bit irq number, zero when not legal
   function automatic logic [15:0] irq_hot(input logic [3:0] sel);
      irq_hot = sel_ok(sel) ? (16'h0001 << sel) : 16'h0000;
   endfunction : irq_hot

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic [7:0] ln;
      logic [15:0] leg;
      logic [3:0] sel;
      ln = 8'h00;
      leg = 16'h0000;
      sel = 4'h0;
      state_next = state_reg;
      // two-flop synchronisers on every interrupt pin and source input; the presence straps take one flop
      state_next.s1_m = ~slot1_int_b_in;
      state_next.s1 = state_reg.s1_m;
      state_next.s2_m = ~slot2_int_b_in;
      state_next.s2 = state_reg.s2_m;
      state_next.lan_m = ~lan_int_b_in;
      state_next.lan = state_reg.lan_m;
      state_next.sys_m = {io_check_in, disk_sec_in, disk_pri_in, fpu_in, mouse_in, rtc_in,
                          parallel_one_in, diskette_in, serial_one_in, cascade_in, kbd_in, timer_in};
      state_next.sys = state_reg.sys_m;
      state_next.dyn_m = dyn_int_in;
      state_next.dyn = state_reg.dyn_m;
      state_next.pres = {disk_sec_present_in, disk_pri_present_in, mouse_present_in};
      // one select for all lines
      state_next.mode = adv_mode_in ? pir_pkg::PIR_MODE_ADV : pir_pkg::PIR_MODE_LEGACY;
      // board wiring of pci pins onto shared lines, or-combined per line
      ln[pir_pkg::LINE_F] = state_reg.s1[0] | state_reg.s2[1];
      ln[pir_pkg::LINE_G] = state_reg.s1[1] | state_reg.s2[0];
      ln[pir_pkg::LINE_H] = state_reg.s1[2] | state_reg.s2[3];
      ln[pir_pkg::LINE_E] = state_reg.s1[3] | state_reg.s2[2];
      ln[pir_pkg::LINE_B] = state_reg.lan;
      state_next.lines = ln;
      // legacy steering, several lines may land on one irq
      for (int i = 0; i < pir_pkg::NUM_LINES; i++)
      begin
         sel = line_sel_in[i*pir_pkg::SEL_W +: pir_pkg::SEL_W];
         if (state_reg.lines[i] && state_reg.mode == pir_pkg::PIR_MODE_LEGACY)
         begin
            leg = leg | irq_hot(sel);
         end
      end
      // dynamic functions take a software chosen irq
      leg = leg | (state_reg.dyn ? irq_hot(dyn_sel_in) : 16'h0000);
      // fixed assignments
      leg[pir_pkg::IRQ_TIMER] = leg[pir_pkg::IRQ_TIMER] | state_reg.sys[0];
      leg[pir_pkg::IRQ_KBD] = leg[pir_pkg::IRQ_KBD] | state_reg.sys[1];
      leg[pir_pkg::IRQ_CASCADE] = state_reg.sys[2];
      leg = leg | (state_reg.sys[3] ? irq_hot(serial_one_sel_in) : 16'h0000);
      leg[pir_pkg::IRQ_DISKETTE] = leg[pir_pkg::IRQ_DISKETTE] | state_reg.sys[4];
      leg = leg | (state_reg.sys[5] ? irq_hot(parallel_one_sel_in) : 16'h0000);
      leg[pir_pkg::IRQ_RTC] = leg[pir_pkg::IRQ_RTC] | state_reg.sys[6];
      leg[pir_pkg::IRQ_MOUSE] = leg[pir_pkg::IRQ_MOUSE] | (state_reg.pres[0] & state_reg.sys[7]);
      leg[pir_pkg::IRQ_FPU] = leg[pir_pkg::IRQ_FPU] | state_reg.sys[8];
      if (state_reg.mode == pir_pkg::PIR_MODE_LEGACY)
      begin
         leg[pir_pkg::IRQ_DISK_PRI] = leg[pir_pkg::IRQ_DISK_PRI] | (state_reg.pres[1] & state_reg.sys[9]);
         leg[pir_pkg::IRQ_DISK_SEC] = leg[pir_pkg::IRQ_DISK_SEC] | (state_reg.pres[2] & state_reg.sys[10]);
      end
      state_next.irq[15:0] = leg;
      // advanced mode: lines a..h straight onto irq16..23, else absent
      if (state_reg.mode == pir_pkg::PIR_MODE_ADV)
      begin
         state_next.irq[23:16] = state_reg.lines;
      end
      else
      begin
         state_next.irq[23:16] = 8'h00;
      end
      state_next.nmi = state_reg.sys[11];
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         state_reg <= '{mode: pir_pkg::PIR_MODE_LEGACY, default: '0};
      end
      else if (clk_en_in)
      begin
         state_reg <= state_next;
      end
   end

   assign shared_line_out = state_reg.lines;
   assign irq_out = state_reg.irq;
   assign nmi_out = state_reg.nmi;
   assign adv_active_out = (state_reg.mode == pir_pkg::PIR_MODE_ADV);
endmodule : pir_router

// ---- testbench/pir_router_props.sv ----
// assertions on the pci interrupt router ports
`timescale 1ns/1ns
module pir_router_props (
   // clock, reset and watched inputs
   input wire logic clk_in, rst_b_in, adv_mode_in, lan_int_b_in,
   input wire logic timer_in, kbd_in, cascade_in, rtc_in, fpu_in, io_check_in,
   input wire logic [3:0] slot1_int_b_in,
   input wire logic [3:0] slot2_int_b_in,
   // watched outputs
   input wire logic [7:0] shared_line_out,
   input wire logic [23:0] irq_out,
   input wire logic nmi_out, adv_active_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // counts edges since reset so that $past never reaches into reset
   logic [2:0] up_reg;
   always_ff @(posedge clk_in)
      up_reg <= !rst_b_in ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
   line_efgh_a: assert property (up_reg == 3'h7 |-> shared_line_out[7:4] ==
      $past(~{slot1_int_b_in[2] & slot2_int_b_in[3], slot1_int_b_in[1] & slot2_int_b_in[0],
      slot1_int_b_in[0] & slot2_int_b_in[1], slot1_int_b_in[3] & slot2_int_b_in[2]}, 3)) else $error("slot lines");
   lan_line_a: assert property (up_reg == 3'h7 |-> shared_line_out[1] == !$past(lan_int_b_in, 3))
      else $error("lan line");
   idle_lines_a: assert property (shared_line_out[0] == 1'b0 && shared_line_out[3:2] == 2'h0)
      else $error("idle lines");
   high_irqs_a: assert property (up_reg == 3'h7 && $stable(adv_active_out) |->
      irq_out[23:16] == (adv_active_out ? $past(shared_line_out) : 8'h00)) else $error("high irqs");
   fixed_irqs_a: assert property (up_reg == 3'h7 |-> {irq_out[13], irq_out[8], irq_out[2:0]} ==
      $past({fpu_in, rtc_in, cascade_in, kbd_in, timer_in}, 3)) else $error("fixed irqs");
   nmi_path_a: assert property (up_reg == 3'h7 |-> nmi_out == $past(io_check_in, 3))
      else $error("nmi");
   mode_follow_a: assert property (up_reg == 3'h7 |-> adv_active_out == $past(adv_mode_in, 1))
      else $error("mode flag");
   reset_clear_a: assert property ($rose(rst_b_in) |-> irq_out == 24'h0 && shared_line_out == 8'h0 && !nmi_out
      && !adv_active_out) else $error("reset outputs");
endmodule : pir_router_props
bind pir_router pir_router_props u_props (.clk_in, .rst_b_in, .adv_mode_in, .lan_int_b_in, .timer_in, .kbd_in,
   .cascade_in, .rtc_in, .fpu_in, .io_check_in, .slot1_int_b_in, .slot2_int_b_in, .shared_line_out, .irq_out,
   .nmi_out, .adv_active_out);

// ---- testbench/pir_card_model.sv ----
// pci cards and onboard lan behind pulled-up active low interrupt pins
`timescale 1ns/1ns
module pir_card_model (
   // clock, requests and interrupt count of each card
   input wire logic clk_in, lan_req_in,
   input wire logic [3:0] s1_req_in, s2_req_in,
   input wire logic [2:0] s1_cnt_in, s2_cnt_in,
   // pins, a released pin reads high
   output logic [3:0] slot1_int_b_out = 4'hF,
   output logic [3:0] slot2_int_b_out = 4'hF,
   output logic lan_int_b_out = 1'b1
);
   always @(posedge clk_in)
   begin
      slot1_int_b_out <= ~(s1_req_in & 4'((5'h01 << s1_cnt_in) - 5'h01));
      slot2_int_b_out <= ~(s2_req_in & 4'((5'h01 << s2_cnt_in) - 5'h01));
      lan_int_b_out <= !lan_req_in;
   end
endmodule : pir_card_model

// ---- testbench/test_pir_router.sv ----
// self-checking bench for the pci interrupt router
`timescale 1ns/1ns
module test_pir_router;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic adv_mode_in = 1'b0;
   logic [31:0] line_sel_in = 32'h0;
   logic [11:0] m = 12'h074;
   logic [15:0] s = 16'h0;
   logic [14:0] r = 15'h0;
   logic [3:0] p1, p2;
   logic pl, nmi_out, adv_active_out;
   logic [7:0] shared_line_out;
   logic [23:0] irq_out;
   logic [33:0] q[$];
   logic [33:0] e;
   int seed = 32'h8FCD;
   int n_mismatch = 0;
   int checks = 0;
   pir_card_model cards (.clk_in, .lan_req_in(r[14]), .s1_req_in(r[3:0]), .s2_req_in(r[7:4]), .s1_cnt_in(r[10:8]),
      .s2_cnt_in(r[13:11]), .slot1_int_b_out(p1), .slot2_int_b_out(p2), .lan_int_b_out(pl));
   pir_router dut (.clk_in, .rst_b_in, .clk_en_in(1'b1), .adv_mode_in, .line_sel_in, .serial_one_sel_in(m[3:0]),
      .parallel_one_sel_in(m[7:4]), .dyn_sel_in(m[11:8]), .mouse_present_in(s[13]), .disk_pri_present_in(s[14]),
      .disk_sec_present_in(s[15]), .slot1_int_b_in(p1), .slot2_int_b_in(p2), .lan_int_b_in(pl), .dyn_int_in(s[12]),
      .timer_in(s[0]), .kbd_in(s[1]), .cascade_in(s[2]), .serial_one_in(s[3]), .diskette_in(s[4]),
      .parallel_one_in(s[5]), .rtc_in(s[6]), .mouse_in(s[7]), .fpu_in(s[8]), .disk_pri_in(s[9]),
      .disk_sec_in(s[10]), .io_check_in(s[11]), .shared_line_out, .irq_out, .nmi_out, .adv_active_out);
   always #25 clk_in = ~clk_in;
   task automatic note();
      logic [3:0] a1, a2, n;
      logic [7:0] ln;
      logic [10:0] lv;
      logic [23:0] ir;
      a1 = r[3:0] & 4'((5'h01 << r[10:8]) - 5'h01);
      a2 = r[7:4] & 4'((5'h01 << r[13:11]) - 5'h01);
      ln = {a1[2] | a2[3], a1[1] | a2[0], a1[0] | a2[1], a1[3] | a2[2], 2'h0, r[14], 1'b0};
      lv = {s[12], s[5], s[3], adv_mode_in ? 8'h00 : ln};
      ir = {adv_mode_in ? ln : 8'h00, s[10] & s[15] & !adv_mode_in, s[9] & s[14] & !adv_mode_in, s[8], s[7] & s[13],
         3'h0, s[6], 1'b0, s[4], 3'h0, s[2:0]};
      for (int i = 0; i < 11; i++)
      begin
         n = i < 8 ? line_sel_in[4 * i +: 4] : m[4 * (i - 8) +: 4];
         ir[n] = ir[n] | (lv[i] & pir_pkg::LEGACY_SEL_MASK[n]);
      end
      q.push_back({ir, ln, s[11], adv_mode_in});
   endtask : note
   task end_sim();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim
   always
   begin
      wait (q.size() > 0);
      e = q.pop_front();
      checks++;
      if ({irq_out, shared_line_out, nmi_out, adv_active_out} !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, {irq_out, shared_line_out, nmi_out, adv_active_out});
      end
   end
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      for (int k = 0; k < 300; k++)
      begin
         @(posedge clk_in);
         r <= 15'($random(seed));
         s <= 16'($random(seed));
         line_sel_in <= $random(seed);
         adv_mode_in <= 1'($random(seed));
         if (k > 0)
            m <= 12'($random(seed));
         repeat (8) @(posedge clk_in);
         #1 note();
      end
      end_sim();
   end
   initial
   begin
      #400000;
      n_mismatch++;
      end_sim();
   end
endmodule : test_pir_router
